// >>> hw/adps_cfg.svh
// Constants of the adapter detect and power selector block
`ifndef ADPS_CFG_SVH
`define ADPS_CFG_SVH

// Clock rate and derived cycles per millisecond
`define ADPS_CLK_MHZ         250
`define ADPS_CYC_PER_MS      (`ADPS_CLK_MHZ * 1000)

// Times in their own units
`define ADPS_T_DG_SHORT_MS   150
`define ADPS_T_DG_LONG_MS    1300
`define ADPS_T_GATE_CHK_MS   20
`define ADPS_T_RETRY_MS      1300
`define ADPS_T_FAIL_WIN_S    90

// Counter widths and failure limit
`define ADPS_TMR_W           35
`define ADPS_DG_W            29
`define ADPS_FAIL_W          3
`define ADPS_FAIL_LIMIT      3'h7

// Register map (byte addresses)
`define ADPS_ADDR_W          4
`define ADPS_REG_OPTION      4'h0
`define ADPS_REG_STATUS      4'h4

// Option word fields and reset value
`define ADPS_OPT_INHIBIT     0
`define ADPS_OPT_CAL         6
`define ADPS_OPT_DGSEL       15
`define ADPS_OPT_RST         16'h8000

// Status word fields
`define ADPS_ST_GOOD         0
`define ADPS_ST_OVP          1
`define ADPS_ST_ACON         2
`define ADPS_ST_BATON        3
`define ADPS_ST_CHG          4
`define ADPS_ST_LATCH        5
`define ADPS_ST_FAIL_LSB     8
`define ADPS_ST_MODE_LSB     12

`endif

// >>> hw/adps_pkg.sv
// Types of the adapter detect and power selector block
`include "adps_cfg.svh"
package adps_pkg;
    // Source selection states
    typedef enum logic [5:0] {
        ADPS_S_BAT   = 6'h01,
        ADPS_S_BRK   = 6'h02,
        ADPS_S_CHK   = 6'h04,
        ADPS_S_RUN   = 6'h08,
        ADPS_S_RETRY = 6'h10,
        ADPS_S_LATCH = 6'h20
    } adps_pwr_e;
    // Rising deglitch selection
    typedef enum logic [2:0] {
        ADPS_DG_FIRST = 3'h1,
        ADPS_DG_LONG  = 3'h2,
        ADPS_DG_OPT   = 3'h4
    } adps_dg_e;
    typedef logic [`ADPS_TMR_W-1:0] adps_tmr_t;
    // Whole state of the block
    typedef struct packed {
        logic [15:0]            opt;
        logic                   pull;
        logic                   ovp;
        logic                   ac_on;
        logic                   bat_on;
        logic                   clamp;
        logic                   chg;
        adps_pwr_e              st;
        adps_dg_e               mode;
        logic                   saw_low;
        logic                   saw_off;
        logic [`ADPS_FAIL_W-1:0] fails;
        adps_tmr_t              tmr;
        adps_tmr_t              win;
        logic [`ADPS_DG_W-1:0]  dg;
        logic                   wreq;
        logic [31:0]            rdata;
    } adps_state_s;
endpackage

// >>> hw/adps_top.sv
// Adapter detect, adapter-good indication and system power source selector
// Behaviour
// - Adapter-good released only with supply ok, detect in window, supply above battery.
// - Adapter-good is open drain: only pulled low or released.
// - First qualification after power-on uses the short deglitch regardless of option.
// - Detect below low threshold resets the block and forces long next deglitch.
// - Option deglitch applies only after detect dropped low and adapter switch turned off.
// - Option bit 15 at zero selects short deglitch; reset default selects long.
// - Register access accepted only with supply above lockout and detect above low level.
// - Over-voltage flags, pulls adapter-good low, stops charge, turns adapter switch off.
// - During over-voltage battery switch turns on when its conditions hold.
// - Detect back in window releases adapter-good, battery off, then adapter on.
// - After over-voltage recovery charging resumes only if all enables hold.
// - At power-on a present battery is connected through the battery switch.
// - Old switch fully off before new one on; never both on.
// - No adapter: adapter gate held at common source, both switches off.
// - Battery gate on without adapter needs supply, battery ok and small adapter margin.
// - After deglitch, move to adapter if adapter-good high and calibrate mode permits.
// - After 20 ms of adapter on, gate voltage low turns switches off.
// - After a failed gate check wait 1.3 s and retry.
// - Seventh failure within 90 s latches adapter off until low-detect reset.
// - Failure counter clears after 90 s.
// - Charging disabled whenever adapter switches are off.
// - Adapter off when adapter-good low or calibrate mode with battery above depletion.
// - Calibrate enable is option bit 6, cleared when battery falls below depletion while adapter-good is released.
`timescale 1ns/1ns
// Shared constants; the guard makes a second inclusion harmless
`include "adps_cfg.svh"
module adps_top #(
    parameter longint unsigned DG_SHORT_CYC =
        longint'(`ADPS_T_DG_SHORT_MS) * longint'(`ADPS_CYC_PER_MS),
    parameter longint unsigned DG_LONG_CYC  =
        longint'(`ADPS_T_DG_LONG_MS) * longint'(`ADPS_CYC_PER_MS),
    parameter longint unsigned GATE_CHK_CYC =
        longint'(`ADPS_T_GATE_CHK_MS) * longint'(`ADPS_CYC_PER_MS),
    parameter longint unsigned RETRY_CYC    =
        longint'(`ADPS_T_RETRY_MS) * longint'(`ADPS_CYC_PER_MS),
    parameter longint unsigned FAIL_WIN_CYC =
        longint'(`ADPS_T_FAIL_WIN_S) * 64'd1000 * longint'(`ADPS_CYC_PER_MS)
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic [`ADPS_ADDR_W-1:0] avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    vcc_above_lockout,
    input  wire logic                    battery_above_lockout,
    input  wire logic                    detect_above_0v6,
    input  wire logic                    detect_above_2v4,
    input  wire logic                    detect_above_3v15,
    input  wire logic                    vcc_above_battery_275m,
    input  wire logic                    adapter_battery_compare,
    input  wire logic                    battery_above_depletion,
    input  wire logic                    adapter_gate_ok,
    input  wire logic                    battery_present,
    input  wire logic                    charge_conditions_ok,
    input  wire logic                    adapter_good_in,
    output logic                         adapter_good_out,
    output logic                         adapter_good_oe,
    output logic                         adapter_overvoltage,
    output logic                         adapter_switch_on,
    output logic                         reverse_block_switch_on,
    output logic                         battery_switch_on,
    output logic                         adapter_gate_clamp,
    output logic                         charge_enable,
    output logic                         adapter_latched
);
    import adps_pkg::*;

    adps_state_s q;
    adps_state_s d;
    logic        qual;
    logic        bus_ok;
    logic        bat_cond;
    logic        ac_off;
    logic [`ADPS_DG_W-1:0] dg_target;
    logic        ac_state_d;
    logic        bat_state_d;

    // Adapter-good qualification and bus enable, all flags synchronous
    assign qual = vcc_above_lockout & detect_above_2v4 & ~detect_above_3v15
                & vcc_above_battery_275m;
    assign bus_ok = vcc_above_lockout & detect_above_0v6;
    assign bat_cond = vcc_above_lockout & battery_above_lockout
                    & adapter_battery_compare & battery_present;
    // Reasons to drop the adapter: adapter-good low or calibrate with the battery above depletion
    assign ac_off = q.pull | (q.opt[`ADPS_OPT_CAL] & battery_above_depletion);

    // Rising deglitch length picked by the current deglitch mode
    always_comb begin
        unique case (q.mode)
            ADPS_DG_FIRST: dg_target = `ADPS_DG_W'(DG_SHORT_CYC);
            ADPS_DG_LONG:  dg_target = `ADPS_DG_W'(DG_LONG_CYC);
            ADPS_DG_OPT: begin
                if (q.opt[`ADPS_OPT_DGSEL]) begin
                    dg_target = `ADPS_DG_W'(DG_LONG_CYC);
                end else begin
                    dg_target = `ADPS_DG_W'(DG_SHORT_CYC);
                end
            end
            default: dg_target = `ADPS_DG_W'(DG_LONG_CYC);
        endcase
    end

    // Next state of the whole block
    always_comb begin
        logic [31:0] stat;
        logic        fail;
        stat = 32'h0;
        fail = 1'b0;
        d = q;
        d.ovp = detect_above_3v15;

        // Adapter-good: falls at once, rises after the deglitch count
        if (!qual) begin
            d.dg = '0;
            d.pull = 1'b1;
        end else if (q.pull) begin
            if (q.dg == dg_target - `ADPS_DG_W'(1)) begin
                d.pull = 1'b0;
            end else begin
                d.dg = q.dg + `ADPS_DG_W'(1);
            end
        end

        // Window that forgets isolated gate failures
        if (q.fails != '0 && q.st != ADPS_S_LATCH) begin
            if (q.win == `ADPS_TMR_W'(FAIL_WIN_CYC - 1)) begin
                d.win = '0;
                d.fails = '0;
            end else begin
                d.win = q.win + `ADPS_TMR_W'(1);
            end
        end

        // Source selection sequence
        d.tmr = q.tmr + `ADPS_TMR_W'(1);
        unique case (q.st)
            ADPS_S_BAT: begin
                if (!q.pull && adapter_good_in && !ac_off) begin
                    d.st = ADPS_S_BRK;
                end
            end
            ADPS_S_BRK: begin
                d.tmr = '0;
                if (ac_off) begin
                    d.st = ADPS_S_BAT;
                end else if (!q.bat_on) begin
                    d.st = ADPS_S_CHK;
                end
            end
            ADPS_S_CHK: begin
                if (ac_off) begin
                    d.st = ADPS_S_BAT;
                end else if (q.tmr == `ADPS_TMR_W'(GATE_CHK_CYC - 1)) begin
                    d.tmr = '0;
                    if (adapter_gate_ok) begin
                        d.st = ADPS_S_RUN;
                    end else begin
                        fail = 1'b1;
                    end
                end
            end
            ADPS_S_RUN: begin
                if (ac_off) begin
                    d.st = ADPS_S_BAT;
                end
            end
            ADPS_S_RETRY: begin
                if (q.tmr == `ADPS_TMR_W'(RETRY_CYC - 1)) begin
                    d.st = ADPS_S_BRK;
                end
            end
            ADPS_S_LATCH: begin
                d.st = ADPS_S_LATCH;
            end
        endcase

        // A failure in the window-clear cycle still counts
        if (fail) begin
            if (q.fails == '0) begin
                d.win = '0;
            end
            d.fails = d.fails + `ADPS_FAIL_W'(1);
            if (d.fails == `ADPS_FAIL_LIMIT) begin
                d.st = ADPS_S_LATCH;
            end else begin
                d.st = ADPS_S_RETRY;
            end
        end

        // Switch drives: each waits for the other's flop to be off
        ac_state_d = (d.st == ADPS_S_CHK) || (d.st == ADPS_S_RUN);
        bat_state_d = (d.st == ADPS_S_BAT) || (d.st == ADPS_S_RETRY)
                    || (d.st == ADPS_S_LATCH);
        d.ac_on = ac_state_d & qual & ~q.bat_on;
        d.bat_on = bat_state_d & bat_cond & ~q.ac_on & ~d.ac_on;
        d.clamp = ~d.ac_on;
        d.chg = d.ac_on & (d.st == ADPS_S_RUN) & ~d.pull & ~d.ovp
              & ~q.opt[`ADPS_OPT_INHIBIT] & charge_conditions_ok;

        // Track what unlocks the option-selected deglitch
        if (!detect_above_2v4) begin
            d.saw_low = 1'b1;
        end
        if (q.ac_on && !d.ac_on) begin
            d.saw_off = 1'b1;
        end
        if (q.mode != ADPS_DG_OPT && d.saw_low && d.saw_off) begin
            d.mode = ADPS_DG_OPT;
        end

        // Calibrate mode ends on a depleted battery
        if (q.opt[`ADPS_OPT_CAL] && !battery_above_depletion && !q.pull) begin
            d.opt[`ADPS_OPT_CAL] = 1'b0;
        end

        // Status word assembled from live state
        stat[`ADPS_ST_GOOD] = ~q.pull;
        stat[`ADPS_ST_OVP] = q.ovp;
        stat[`ADPS_ST_ACON] = q.ac_on;
        stat[`ADPS_ST_BATON] = q.bat_on;
        stat[`ADPS_ST_CHG] = q.chg;
        stat[`ADPS_ST_LATCH] = (q.st == ADPS_S_LATCH);
        stat[`ADPS_ST_FAIL_LSB +: `ADPS_FAIL_W] = q.fails;
        stat[`ADPS_ST_MODE_LSB +: 3] = q.mode;

        // Bus slave: one wait cycle, then a one-cycle answer
        if (q.wreq && (avs_read || avs_write)) begin
            d.wreq = 1'b0;
            d.rdata = 32'h0;
            if (bus_ok && avs_read) begin
                if (avs_address == `ADPS_REG_OPTION) begin
                    d.rdata = {16'h0, q.opt};
                end else if (avs_address == `ADPS_REG_STATUS) begin
                    d.rdata = stat;
                end
            end
        end else if (!q.wreq) begin
            d.wreq = 1'b1;
            if (bus_ok && avs_write && avs_address == `ADPS_REG_OPTION) begin
                if (avs_byteenable[0]) begin
                    d.opt[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    d.opt[15:8] = avs_writedata[15:8];
                end
            end
        end

        // Detect below the low level resets all but the bus handshake
        if (!detect_above_0v6) begin
            d.opt = `ADPS_OPT_RST;
            d.pull = 1'b1;
            d.ovp = 1'b0;
            d.ac_on = 1'b0;
            d.bat_on = bat_cond & ~q.ac_on;
            d.clamp = 1'b1;
            d.chg = 1'b0;
            d.st = ADPS_S_BAT;
            d.mode = ADPS_DG_LONG;
            d.saw_low = 1'b0;
            d.saw_off = 1'b0;
            d.fails = '0;
            d.tmr = '0;
            d.win = '0;
            d.dg = '0;
        end
    end

    // State register; power-on starts with the short first deglitch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q.opt <= `ADPS_OPT_RST;
            q.pull <= 1'b1;
            q.ovp <= 1'b0;
            q.ac_on <= 1'b0;
            q.bat_on <= 1'b0;
            q.clamp <= 1'b1;
            q.chg <= 1'b0;
            q.st <= ADPS_S_BAT;
            q.mode <= ADPS_DG_FIRST;
            q.saw_low <= 1'b0;
            q.saw_off <= 1'b0;
            q.fails <= '0;
            q.tmr <= '0;
            q.win <= '0;
            q.dg <= '0;
            q.wreq <= 1'b1;
            q.rdata <= 32'h0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops; the pin never drives high
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign adapter_good_out = 1'b0;
    assign adapter_good_oe = q.pull;
    assign adapter_overvoltage = q.ovp;
    assign adapter_switch_on = q.ac_on;
    assign reverse_block_switch_on = q.ac_on;
    assign battery_switch_on = q.bat_on;
    assign adapter_gate_clamp = q.clamp;
    assign charge_enable = q.chg;
    assign adapter_latched = (q.st == ADPS_S_LATCH);

    // Checks of the sequencing
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence gate_fail_s;
        q.st == ADPS_S_CHK && !ac_off && !adapter_gate_ok && detect_above_0v6
        && q.tmr == `ADPS_TMR_W'(GATE_CHK_CYC - 1);
    endsequence
    sequence switches_off_s;
        !adapter_switch_on && !charge_enable;
    endsequence

    good_qual_a: assert property (!qual |=> adapter_good_oe)
        else $error("adapter-good released without qualification");
    od_pin_a: assert property (!adapter_good_out)
        else $error("adapter-good pin driven high");
    dg_length_a: assert property ($fell(q.pull) |->
        $past(q.dg) == $past(dg_target) - `ADPS_DG_W'(1))
        else $error("adapter-good rose before the deglitch count");
    first_dg_a: assert property ($fell(q.pull) && $past(q.mode) == ADPS_DG_FIRST
        |-> $past(q.dg) == `ADPS_DG_W'(DG_SHORT_CYC - 1))
        else $error("first deglitch not short");
    low_reset_a: assert property (!detect_above_0v6 |=> q.mode == ADPS_DG_LONG
        && q.st == ADPS_S_BAT && q.fails == '0)
        else $error("low detect did not reset the block");
    opt_unlock_a: assert property ($rose(q.mode == ADPS_DG_OPT) |->
        $past(q.saw_low) || q.saw_low)
        else $error("option deglitch unlocked too early");
    opt_short_a: assert property ($fell(q.pull) && $past(q.mode) == ADPS_DG_OPT
        && !$past(q.opt[`ADPS_OPT_DGSEL]) |-> $past(q.dg) == `ADPS_DG_W'(DG_SHORT_CYC - 1))
        else $error("option bit did not select short deglitch");
    bus_gate_a: assert property (avs_read && avs_waitrequest && !bus_ok
        |=> avs_readdata == 32'h0)
        else $error("register read answered while bus disabled");
    ovp_off_a: assert property (detect_above_3v15 |=> switches_off_s
        and adapter_good_oe)
        else $error("over-voltage left adapter path on");
    no_overlap_a: assert property (!(adapter_switch_on && battery_switch_on)
        and ($fell(adapter_switch_on) |-> !battery_switch_on))
        else $error("adapter and battery switches overlap");
    gate_fail_a: assert property (gate_fail_s |=> !adapter_switch_on
        && (q.st == ADPS_S_RETRY || q.st == ADPS_S_LATCH))
        else $error("failed gate check kept adapter on");
    latch_hold_a: assert property (q.st == ADPS_S_LATCH && detect_above_0v6
        |=> adapter_latched && !adapter_switch_on)
        else $error("latched adapter came back on");
    chg_off_a: assert property (!adapter_switch_on |-> !charge_enable)
        else $error("charging with adapter switches off");
    cal_off_a: assert property (adapter_switch_on && q.opt[`ADPS_OPT_CAL]
        && battery_above_depletion && detect_above_0v6 ##1 1 |=> !adapter_switch_on)
        else $error("calibrate mode did not drop adapter");

    // Retry idles the adapter; the battery needs its conditions one cycle earlier
    retry_off_a: assert property (q.st == ADPS_S_RETRY |-> !adapter_switch_on)
        else $error("adapter on during retry wait");
    bat_cond_a: assert property (battery_switch_on |-> $past(bat_cond))
        else $error("battery switch on without its conditions");
    ovp_flag_a: assert property (detect_above_3v15 && detect_above_0v6
        |=> adapter_overvoltage)
        else $error("over-voltage not flagged");

endmodule // adps_top

// >>> tb/adps_switch_model.sv
// Adapter switch pair and open-drain adapter-good wire outside the block
`timescale 1ns/1ns
module adps_switch_model #(
    parameter int RISE_CYC = 3
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic adapter_switch_on,
    input  wire logic adapter_good_out,
    input  wire logic adapter_good_oe,
    input  wire logic gate_slow,
    output logic      adapter_gate_ok,
    output logic      adapter_good_in
);
    int rise_q;
    // Pull-up gives the high level whenever nobody pulls low
    assign adapter_good_in = adapter_good_oe ? adapter_good_out : 1'b1;
    // Gate charges a few cycles after drive; a weak pump never gets there
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rise_q <= 0;
        end else if (!adapter_switch_on) begin
            rise_q <= 0;
        end else if (rise_q < RISE_CYC) begin
            rise_q <= rise_q + 1;
        end
    end
    assign adapter_gate_ok = !gate_slow && (rise_q >= RISE_CYC);
endmodule // adps_switch_model

// >>> tb/testbench.sv
// Self-checking bench for the adapter detect and power selector
`timescale 1ns/1ns
module testbench;
    // Short counts keep the run brief; expectations derive from them
    localparam int DG_S = 20, DG_L = 50, CHK = 10, RTY = 30, WIN = 400;
    logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic vcc_above_lockout = 1'b1, battery_above_lockout = 1'b1;
    logic detect_above_0v6 = 1'b1, detect_above_2v4 = 1'b0, detect_above_3v15 = 1'b0;
    logic vcc_above_battery_275m = 1'b1, adapter_battery_compare = 1'b1;
    logic battery_above_depletion = 1'b1, battery_present = 1'b1;
    logic charge_conditions_ok = 1'b1, gate_slow = 1'b0;
    logic avs_waitrequest, adapter_good_out, adapter_good_oe, adapter_overvoltage;
    logic adapter_switch_on, reverse_block_switch_on, battery_switch_on;
    logic adapter_gate_clamp, charge_enable, adapter_latched, adapter_gate_ok;
    logic adapter_good_in;
    int n_fail = 0, num_checks = 0, n;

    always #2 sys_clk = ~sys_clk;

    adps_top #(.DG_SHORT_CYC(DG_S), .DG_LONG_CYC(DG_L), .GATE_CHK_CYC(CHK),
               .RETRY_CYC(RTY), .FAIL_WIN_CYC(WIN)) dut (
        .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .vcc_above_lockout,
        .battery_above_lockout, .detect_above_0v6, .detect_above_2v4,
        .detect_above_3v15, .vcc_above_battery_275m, .adapter_battery_compare,
        .battery_above_depletion, .adapter_gate_ok, .battery_present,
        .charge_conditions_ok, .adapter_good_in, .adapter_good_out, .adapter_good_oe,
        .adapter_overvoltage, .adapter_switch_on, .reverse_block_switch_on,
        .battery_switch_on, .adapter_gate_clamp, .charge_enable, .adapter_latched);

    adps_switch_model model (.sys_clk, .reset, .adapter_switch_on, .adapter_good_out,
        .adapter_good_oe, .gate_slow, .adapter_gate_ok, .adapter_good_in);

    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle counts are judged against a window, not one exact edge
    task automatic chk_range(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask

    // One Avalon access; an idle edge first so a release never meets a new request
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        if (k >= 50) n_fail++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_word(q, exp);
    endtask

    // Waits for the good pin pull (sel=1) or the adapter switch to reach v
    task automatic wt(input bit sel, input logic v);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((sel ? adapter_good_oe : adapter_switch_on) !== v && n < 500);
        if (n >= 500) n_fail++;
    endtask

    // Standing relations between the outputs, every cycle out of reset
    always @(posedge sys_clk) begin
        if (reset === 1'b0) begin
            chk_bit(adapter_switch_on & battery_switch_on, 1'b0);
            chk_bit(charge_enable & ~adapter_switch_on, 1'b0);
            chk_bit(adapter_gate_clamp, ~adapter_switch_on);
            chk_bit(adapter_good_out, 1'b0);
            chk_bit(reverse_block_switch_on, adapter_switch_on);
        end
    end

    // Main sequence
    initial begin
        cyc(4);
        reset <= 1'b0;
        cyc(3);
        chk_bit(battery_switch_on, 1'b1);
        chk_bit(adapter_good_oe, 1'b1);
        rd(4'h0, 32'h0000_8000);
        rd(4'h8, 32'h0000_0000);
        detect_above_2v4 <= 1'b1;
        wt(1, 1'b0);
        chk_range(n, DG_S, DG_S + 4);
        wt(0, 1'b1);
        cyc(CHK + 4);
        chk_bit(charge_enable, 1'b1);
        // Over-voltage and recovery, charge held back on recovery first
        detect_above_3v15 <= 1'b1;
        cyc(3);
        chk_bit(adapter_overvoltage, 1'b1);
        chk_bit(adapter_good_oe, 1'b1);
        chk_bit(adapter_switch_on, 1'b0);
        cyc(3);
        chk_bit(battery_switch_on, 1'b1);
        adapter_battery_compare <= 1'b0;
        cyc(3);
        chk_bit(battery_switch_on, 1'b0);
        adapter_battery_compare <= 1'b1;
        battery_present <= 1'b0;
        cyc(3);
        chk_bit(battery_switch_on, 1'b0);
        battery_present <= 1'b1;
        charge_conditions_ok <= 1'b0;
        detect_above_3v15 <= 1'b0;
        wt(0, 1'b1);
        chk_bit(adapter_good_oe, 1'b0);
        cyc(CHK + 4);
        chk_bit(charge_enable, 1'b0);
        charge_conditions_ok <= 1'b1;
        cyc(3);
        chk_bit(charge_enable, 1'b1);
        // Calibrate mode forces battery, ends at depletion
        bus(1'b1, 4'h0, 32'h0000_8040);
        cyc(3);
        chk_bit(adapter_switch_on, 1'b0);
        battery_above_depletion <= 1'b0;
        wt(0, 1'b1);
        rd(4'h0, 32'h0000_8000);
        battery_above_depletion <= 1'b1;
        // A write with the supply low is dropped
        vcc_above_lockout <= 1'b0;
        bus(1'b1, 4'h0, 32'h0000_0000);
        rd(4'h0, 32'h0000_0000);
        chk_bit(adapter_good_oe, 1'b1);
        vcc_above_lockout <= 1'b1;
        rd(4'h0, 32'h0000_8000);
        // Low detect resets and forces the long deglitch
        detect_above_0v6 <= 1'b0;
        detect_above_2v4 <= 1'b0;
        cyc(3);
        detect_above_0v6 <= 1'b1;
        detect_above_2v4 <= 1'b1;
        wt(1, 1'b0);
        chk_range(n, DG_L, DG_L + 4);
        wt(0, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0000);
        detect_above_2v4 <= 1'b0;
        wt(0, 1'b0);
        cyc(2);
        detect_above_2v4 <= 1'b1;
        wt(1, 1'b0);
        chk_range(n, DG_S, DG_S + 4);
        // Weak gate: seven failures end in latch-off
        gate_slow <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wt(0, 1'b1);
            // The two idle edges before the latch check belong to the retry wait
            if (i > 0) chk_range(n + 2, RTY, RTY + 6);
            wt(0, 1'b0);
            chk_range(n, CHK, CHK + 4);
            cyc(2);
            chk_bit(adapter_latched, 1'(i == 6));
        end
        cyc(100);
        chk_bit(adapter_switch_on, 1'b0);
        detect_above_0v6 <= 1'b0;
        detect_above_2v4 <= 1'b0;
        cyc(3);
        chk_bit(adapter_latched, 1'b0);
        detect_above_0v6 <= 1'b1;
        detect_above_2v4 <= 1'b1;
        // Isolated failures are forgotten once the window runs out
        repeat (3) begin
            wt(0, 1'b1);
            wt(0, 1'b0);
        end
        gate_slow <= 1'b0;
        bus(1'b0, 4'h4, 32'h0);
        chk_word({29'h0, q[10:8]}, 32'h0000_0003);
        cyc(WIN);
        bus(1'b0, 4'h4, 32'h0);
        chk_word({29'h0, q[10:8]}, 32'h0000_0000);
        complete_run;
    end

    // Watchdog well beyond the fewer than two thousand cycles the sequence needs
    initial begin
        cyc(20000);
        n_fail++;
        complete_run;
    end
endmodule // testbench
